// file: shared/sfq_regs.vh
// Purpose: constants shared by the flash command interpreter files
// Assumes: 100 MHz core clock, times kept in their own unit
// Notes:   cycle counts are derived inside the modules
`ifndef SFQ_REGS_VH
`define SFQ_REGS_VH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define SFQ_OP_WREN    8'h06
`define SFQ_OP_RDSR    8'h05
`define SFQ_OP_SEC_ER  8'h44
`define SFQ_OP_SEC_PG  8'h42
`define SFQ_OP_SEC_RD  8'h48
`define SFQ_OP_SET_RP  8'hC0
`define SFQ_OP_WRAP_RD 8'h0C
`define SFQ_OP_QPI_EN  8'h38
`define SFQ_OP_QPI_DIS 8'hFF
`define SFQ_OP_RST_ARM 8'h66
`define SFQ_OP_RST     8'h99
// ----------------------------------------
// frame positions, counted in received bits
// ----------------------------------------
`define SFQ_OPC_END    12'h008
`define SFQ_PARAM_END  12'h010
`define SFQ_ADDR_END   12'h020
`define SFQ_SEC_DUMMY  12'h008
`define SFQ_DCLK_MIN   12'h002
`define SFQ_BITS_SPI   12'h001
`define SFQ_BITS_QPI   12'h004
`define SFQ_BYTE_BITS  4'h8
`define SFQ_OE_SPI     4'h2
`define SFQ_OE_QPI     4'hF
`define SFQ_OE_OFF     4'h0
// ----------------------------------------
// status and read parameter fields
// ----------------------------------------
`define SFQ_STAT_WIP   0
`define SFQ_STAT_WEL   1
`define SFQ_RP_DUMMY   5:4
`define SFQ_RP_WRAP    1:0
`define SFQ_RP_RESET   8'h00
`define SFQ_WRAP_MIN   3'h7
`define SFQ_ERASED     8'hFF
// ----------------------------------------
// timing
// ----------------------------------------
`define SFQ_CLK_MHZ     100
`define SFQ_NS_PER_US   1000
`define SFQ_SE_TIME_US  100
`define SFQ_PP_TIME_NS  1000
`define SFQ_RST_TIME_US 30
`endif

// file: hw/sfq_sync.v
// Purpose: two-stage synchroniser for pins from outside the clock domain
// Assumes: inputs are quasi-static or slow against CLK
// Notes:   only the second stage is visible outside
`timescale 1ns/1ps
module sfq_sync #(
	parameter W = 1
)(
	input  wire         clk,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta_r;

	always @(posedge clk) begin
		meta_r <= d;
		q      <= meta_r;
	end
endmodule // sfq_sync

// file: hw/sfq_secmem.v
// Purpose: security sector storage with bit-clearing program and erase sweep
// Assumes: no program while the sweep runs
// Notes:   read data lags the address by one clock
`timescale 1ns/1ps
`include "sfq_regs.vh"
module sfq_secmem #(
	parameter AW = 10
)(
	input  wire          clk,
	input  wire          srst,
	input  wire [AW-1:0] rd_addr,
	output reg  [7:0]    rd_data,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [7:0]    wr_data,
	input  wire          erase
);
	reg [7:0]    mem [0:(1<<AW)-1];
	reg [AW-1:0] er_cnt_r;
	reg          er_act_r;

	always @(posedge clk) begin
		if (srst) begin
			er_act_r <= 1'b0;
			er_cnt_r <= {AW{1'b0}};
		end else if (erase) begin
			er_act_r <= 1'b1;
			er_cnt_r <= {AW{1'b0}};
		end else if (er_act_r) begin
			er_cnt_r <= er_cnt_r + 1'b1;
			er_act_r <= ~(&er_cnt_r);
		end
	end

	// flash cells can only go from one to zero when programmed
	always @(posedge clk) begin
		rd_data <= mem[rd_addr];
		if (er_act_r)
			mem[er_cnt_r] <= `SFQ_ERASED;
		else if (wr_en)
			mem[wr_addr] <= mem[wr_addr] & wr_data;
	end
endmodule // sfq_secmem

// file: hw/sfq_core.v
// Purpose: SPI/QPI command interpreter for security sector, read params, mode switch, reset
// Assumes: SCLK, CS_N and IO_IN are asynchronous pins; QUAD_ENABLE, SECURITY_LOCK
//          and ARRAY_DATA come from logic on CLK
// Notes:   SCLK must stay well below CLK/2 so every link edge is seen
//
// Notes on behaviour
// (R1) erase needs write latch, 24-bit address
// (R2) erase only if CS rises at boundary
// (R3) erase self-timed, in-progress flag, status readable
// (R4) erase completion clears write latch
// (R5) lock bit blocks sector erase and program
// (R6) program needs write latch, 1..256 bytes
// (R7) host keeps CS low through program
// (R8) read: opcode, address, eight dummy clocks
// (R9) sample on rise, drive on fall, MSB first
// (R10) read address increments, wraps at sector end
// (R11) read params QPI only, dummy 2/4/6/8
// (R12) wrap field selects 8/16/32/64 bytes
// (R13) reset default: 8-byte wrap, 2 dummies
// (R14) wrapped read wraps within aligned window
// (R15) enter QPI only with quad enable
// (R16) power up SPI; QPI entered only by command
// (R17) mode switch keeps latch and wrap setting
// (R18) exit QPI returns to SPI mode
// (R19) reset only directly after arm command
// (R20) reset clears latch, params, mode, operations
// (R21) no commands during reset recovery
// (R22) host checks in-progress before reset
// (R23) low ten address bits are sector offset
`timescale 1ns/1ps
`include "sfq_regs.vh"
module sfq_core #(
	parameter [23:0] SE_CYCLES  = `SFQ_SE_TIME_US * `SFQ_CLK_MHZ,
	parameter [23:0] RST_CYCLES = `SFQ_RST_TIME_US * `SFQ_CLK_MHZ
)(
	input  wire        CLK,
	input  wire        SRST,
	input  wire        SCLK,
	input  wire        CS_N,
	input  wire [3:0]  IO_IN,
	output wire [3:0]  IO_OUT,
	output wire [3:0]  IO_OE,
	input  wire        QUAD_ENABLE,
	input  wire        SECURITY_LOCK,
	input  wire [7:0]  ARRAY_DATA,
	output wire [23:0] ARRAY_ADDR,
	output wire        IN_PROGRESS,
	output wire        WRITE_LATCH,
	output wire        QPI_MODE,
	output wire [7:0]  READ_PARAM,
	output wire        RESET_RECOVERY
);
	localparam [23:0] PP_CYC = (`SFQ_PP_TIME_NS * `SFQ_CLK_MHZ + `SFQ_NS_PER_US - 1) / `SFQ_NS_PER_US;

	// ----------------------------------------
	// pin synchronisers and link edges
	// ----------------------------------------
	wire       sck_s;
	wire       cs_s;
	wire [3:0] io_s;
	reg        sck_d_r;
	reg        cs_d_r;

	sfq_sync #(.W(6)) u_sync (
		.clk (CLK),
		.d   ({SCLK, CS_N, IO_IN}),
		.q   ({sck_s, cs_s, io_s})
	);

	wire sck_rise = sck_s & ~sck_d_r & ~cs_s;
	wire sck_fall = ~sck_s & sck_d_r & ~cs_s;
	wire cs_up    = cs_s & ~cs_d_r;

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [11:0] bit_cnt_r;
	reg [7:0]  sh_r;
	reg [7:0]  op_r;
	reg        ok_r;
	reg        arm_r;
	reg        wel_r;
	reg        wip_r;
	reg        qpi_r;
	reg        rrec_r;
	reg        pg_seen_r;
	reg [23:0] addr_r;
	reg [23:0] arr_addr_r;
	reg [23:0] tmr_r;
	reg [23:0] rtmr_r;
	reg [7:0]  rp_r;
	reg [7:0]  oshift_r;
	reg [3:0]  obit_r;
	reg [3:0]  io_out_r;
	reg [3:0]  io_oe_r;
	reg        wr_en_r;
	reg [9:0]  wr_addr_r;
	reg [7:0]  wr_data_r;
	reg        erase_r;
	wire [7:0] mem_rdata;

	sfq_secmem #(.AW(10)) u_mem (
		.clk     (CLK),
		.srst    (SRST),
		.rd_addr (addr_r[9:0]), // see (R23)
		.rd_data (mem_rdata),
		.wr_en   (wr_en_r),
		.wr_addr (wr_addr_r),
		.wr_data (wr_data_r),
		.erase   (erase_r)
	);

	// ----------------------------------------
	// decoders
	// ----------------------------------------
	function [11:0] dclk;
		input [1:0] c;
		begin
			dclk = {9'h000, c, 1'b0} + `SFQ_DCLK_MIN; // see (R11)
		end
	endfunction

	function [5:0] wmask;
		input [1:0] c;
		begin
			wmask = {c == 2'h3, c[1], |c, `SFQ_WRAP_MIN}; // see (R12)
		end
	endfunction

	wire [11:0] step    = qpi_r ? `SFQ_BITS_QPI : `SFQ_BITS_SPI;
	wire [11:0] bit_nxt = bit_cnt_r + step;
	wire [7:0]  sh_nxt  = qpi_r ? {sh_r[3:0], io_s} : {sh_r[6:0], io_s[0]}; // see (R9)
	wire        byte_done = sck_rise & (bit_nxt[2:0] == 3'h0);
	wire        at_opc  = sck_rise & (bit_nxt == `SFQ_OPC_END);
	wire [5:0]  wm      = wmask(rp_r[`SFQ_RP_WRAP]);

	reg        acc;
	reg [11:0] dstart;
	reg        rd_op;
	reg [7:0]  obyte;
	reg [7:0]  osel;

	always @* begin
		case (sh_nxt)
			`SFQ_OP_WREN, `SFQ_OP_RDSR, `SFQ_OP_SEC_RD, `SFQ_OP_RST_ARM: acc = 1'b1;
			`SFQ_OP_SEC_ER, `SFQ_OP_SEC_PG: acc = wel_r & ~SECURITY_LOCK; // see (R1) (R5) (R6)
			`SFQ_OP_SET_RP, `SFQ_OP_WRAP_RD, `SFQ_OP_QPI_DIS: acc = qpi_r; // see (R11) (R18)
			`SFQ_OP_QPI_EN: acc = ~qpi_r & QUAD_ENABLE; // see (R15)
			`SFQ_OP_RST: acc = arm_r; // see (R19)
			default: acc = 1'b0;
		endcase
		// busy: only status polls and the reset pair get through
		if (wip_r && sh_nxt != `SFQ_OP_RDSR && sh_nxt != `SFQ_OP_RST_ARM && sh_nxt != `SFQ_OP_RST)
			acc = 1'b0; // see (R3)
		if (rrec_r)
			acc = 1'b0; // see (R21)
	end

	always @* begin
		rd_op = 1'b1;
		case (op_r)
			`SFQ_OP_RDSR: dstart = `SFQ_OPC_END;
			`SFQ_OP_SEC_RD: dstart = `SFQ_ADDR_END + (qpi_r ? (`SFQ_SEC_DUMMY << 2) : `SFQ_SEC_DUMMY); // see (R8)
			`SFQ_OP_WRAP_RD: dstart = `SFQ_ADDR_END + (dclk(rp_r[`SFQ_RP_DUMMY]) << 2); // see (R14)
			default: begin
				dstart = `SFQ_ADDR_END;
				rd_op  = 1'b0;
			end
		endcase
	end

	always @* begin
		obyte = `SFQ_RP_RESET;
		if (op_r == `SFQ_OP_RDSR) begin
			obyte[`SFQ_STAT_WIP] = wip_r; // see (R3)
			obyte[`SFQ_STAT_WEL] = wel_r;
		end else if (op_r == `SFQ_OP_SEC_RD)
			obyte = mem_rdata;
		else
			obyte = ARRAY_DATA;
		osel = (obit_r == 4'h0) ? obyte : oshift_r;
	end

	// ----------------------------------------
	// command engine
	// ----------------------------------------
	always @(posedge CLK) begin
		if (SRST) begin
			sck_d_r    <= 1'b0;
			cs_d_r     <= 1'b1;
			bit_cnt_r  <= 12'h000;
			sh_r       <= 8'h00;
			op_r       <= 8'h00;
			ok_r       <= 1'b0;
			arm_r      <= 1'b0;
			wel_r      <= 1'b0;
			wip_r      <= 1'b0;
			qpi_r      <= 1'b0; // see (R16)
			rrec_r     <= 1'b0;
			pg_seen_r  <= 1'b0;
			addr_r     <= 24'h00_0000;
			arr_addr_r <= 24'h00_0000;
			tmr_r      <= 24'h00_0000;
			rtmr_r     <= 24'h00_0000;
			rp_r       <= `SFQ_RP_RESET; // see (R13)
			oshift_r   <= 8'h00;
			obit_r     <= 4'h0;
			io_out_r   <= 4'h0;
			io_oe_r    <= `SFQ_OE_OFF;
			wr_en_r    <= 1'b0;
			wr_addr_r  <= 10'h000;
			wr_data_r  <= 8'h00;
			erase_r    <= 1'b0;
		end else begin
			sck_d_r    <= sck_s;
			cs_d_r     <= cs_s;
			wr_en_r    <= 1'b0;
			erase_r    <= 1'b0;
			arr_addr_r <= addr_r;
			if (wip_r) begin
				if (tmr_r <= 24'h00_0001) begin
					wip_r <= 1'b0; // see (R3)
					wel_r <= 1'b0; // see (R4)
				end else
					tmr_r <= tmr_r - 24'h00_0001;
			end
			if (rrec_r) begin
				if (rtmr_r <= 24'h00_0001)
					rrec_r <= 1'b0;
				else
					rtmr_r <= rtmr_r - 24'h00_0001;
			end
			if (cs_s) begin
				bit_cnt_r <= 12'h000;
				obit_r    <= 4'h0;
				io_oe_r   <= `SFQ_OE_OFF;
				ok_r      <= 1'b0;
				pg_seen_r <= 1'b0;
				if (cs_up && ok_r) begin
					case (op_r)
						`SFQ_OP_WREN:
							if (bit_cnt_r == `SFQ_OPC_END)
								wel_r <= 1'b1;
						`SFQ_OP_SEC_ER:
							if (bit_cnt_r == `SFQ_ADDR_END) begin // see (R2)
								wip_r   <= 1'b1; // see (R3)
								tmr_r   <= SE_CYCLES;
								erase_r <= 1'b1;
							end
						`SFQ_OP_SEC_PG:
							if (pg_seen_r && bit_cnt_r[2:0] == 3'h0) begin
								wip_r <= 1'b1;
								tmr_r <= PP_CYC;
							end
						// mode flips touch nothing but the mode itself
						`SFQ_OP_QPI_EN:
							if (bit_cnt_r == `SFQ_OPC_END)
								qpi_r <= 1'b1; // see (R15) (R17)
						`SFQ_OP_QPI_DIS:
							if (bit_cnt_r == `SFQ_OPC_END)
								qpi_r <= 1'b0; // see (R18) (R17)
						`SFQ_OP_RST:
							if (bit_cnt_r == `SFQ_OPC_END) begin // see (R20)
								wip_r  <= 1'b0;
								wel_r  <= 1'b0;
								qpi_r  <= 1'b0;
								rp_r   <= `SFQ_RP_RESET; // see (R13)
								arm_r  <= 1'b0;
								rrec_r <= 1'b1; // see (R21)
								rtmr_r <= RST_CYCLES;
							end
						default: ;
					endcase
				end
			end else begin
				if (sck_rise) begin
					bit_cnt_r <= bit_nxt;
					sh_r      <= sh_nxt;
					if (at_opc) begin
						op_r <= sh_nxt;
						ok_r <= acc;
						// any opcode other than the arm command itself disarms
						if (!rrec_r)
							arm_r <= (sh_nxt == `SFQ_OP_RST_ARM); // see (R19)
					end
					if (ok_r && bit_cnt_r >= `SFQ_OPC_END && bit_cnt_r < `SFQ_ADDR_END)
						addr_r <= qpi_r ? {addr_r[19:0], io_s} : {addr_r[22:0], io_s[0]}; // see (R9)
					if (ok_r && byte_done && op_r == `SFQ_OP_SET_RP && bit_nxt == `SFQ_PARAM_END)
						rp_r <= sh_nxt; // see (R11) (R12)
					// each byte programs at once; page offset wraps so at most 256 land
					if (ok_r && byte_done && op_r == `SFQ_OP_SEC_PG && bit_nxt > `SFQ_ADDR_END) begin
						wr_en_r     <= 1'b1; // see (R6)
						wr_addr_r   <= addr_r[9:0]; // see (R23)
						wr_data_r   <= sh_nxt;
						addr_r[7:0] <= addr_r[7:0] + 8'h01;
						pg_seen_r   <= 1'b1;
					end
				end
				if (sck_fall && ok_r && rd_op && bit_cnt_r >= dstart) begin
					if (qpi_r) begin
						io_out_r <= osel[7:4];
						io_oe_r  <= `SFQ_OE_QPI;
						oshift_r <= {osel[3:0], 4'h0};
					end else begin
						io_out_r <= {2'b00, osel[7], 1'b0}; // see (R9)
						io_oe_r  <= `SFQ_OE_SPI;
						oshift_r <= {osel[6:0], 1'b0};
					end
					obit_r <= ((obit_r == 4'h0) ? `SFQ_BYTE_BITS : obit_r) - step[3:0];
					if (obit_r == 4'h0) begin
						if (op_r == `SFQ_OP_SEC_RD)
							addr_r[9:0] <= addr_r[9:0] + 10'h001; // see (R10)
						else if (op_r == `SFQ_OP_WRAP_RD)
							addr_r[5:0] <= (addr_r[5:0] & ~wm) | ((addr_r[5:0] + 6'h01) & wm); // see (R14)
					end
				end
			end
		end
	end

	assign IO_OUT         = io_out_r;
	assign IO_OE          = io_oe_r;
	assign ARRAY_ADDR     = arr_addr_r;
	assign IN_PROGRESS    = wip_r;
	assign WRITE_LATCH    = wel_r;
	assign QPI_MODE       = qpi_r;
	assign READ_PARAM     = rp_r;
	assign RESET_RECOVERY = rrec_r;
endmodule // sfq_core

// file: tb/sfq_host.sv
// Purpose: host controller model driving link frames into the flash core
// Assumes: link period 80 ns, frames start after reset settles
// Notes:   read samples taken just before each rising link edge
`timescale 1ns/1ps
module sfq_host (
	input  wire logic       clk,
	input  wire logic [3:0] io_out,
	input  wire logic [3:0] io_oe,
	output logic            sclk,
	output logic            cs_n,
	output logic [3:0]      io_in
);
	logic [63:0] rd;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io_in = 4'h0;
		rd = 64'h0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// n link clocks of v, msb first; q picks nibble mode
	task automatic frm(input logic [63:0] v, input int n, input bit q);
		wt(1);
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			io_in = q ? v[63:60] : {~v[63], ~v[63], ~v[63], v[63]};
			wt(4);
			// a line the device does not drive reads back inverted, so a missing enable shows
			rd = q ? {rd[59:0], io_out ^ ~io_oe} : {rd[62:0], io_out[1] ^ ~io_oe[1]};
			sclk = 1'b1;
			v = q ? v << 4 : v << 1;
			wt(4);
			sclk = 1'b0;
		end
		wt(4);
		cs_n = 1'b1;
		io_in = ~io_in;
		wt(6);
	endtask
endmodule // sfq_host

// file: tb/sfq_core_sva.sv
// Purpose: port-level checks of the flash command interpreter
// Assumes: single CLK domain, SRST synchronous
// Notes:   bound to every sfq_core instance
`timescale 1ns/1ps
module sfq_core_sva (
	input wire        CLK,
	input wire        SRST,
	input wire        CS_N,
	input wire [3:0]  IO_OE,
	input wire        QUAD_ENABLE,
	input wire        SECURITY_LOCK,
	input wire        IN_PROGRESS,
	input wire        WRITE_LATCH,
	input wire        QPI_MODE,
	input wire [7:0]  READ_PARAM,
	input wire        RESET_RECOVERY
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	sequence cs_idle;
		CS_N [*6];
	endsequence
	sequence busy_run;
		IN_PROGRESS [*8];
	endsequence
	AST_OE_WIDTH: assert property (IO_OE != 4'h0 |-> IO_OE == (QPI_MODE ? 4'hF : 4'h2))
		else $error("output enable width wrong for mode");
	AST_OE_IDLE: assert property (cs_idle |-> IO_OE == 4'h0)
		else $error("output driven outside a frame");
	AST_QPI_ENTRY: assert property ($rose(QPI_MODE) |-> QUAD_ENABLE && $stable(WRITE_LATCH) && $stable(READ_PARAM))
		else $error("bad entry into nibble mode");
	AST_BUSY_CAUSE: assert property ($rose(IN_PROGRESS) |-> $past(WRITE_LATCH) && !SECURITY_LOCK)
		else $error("operation started without latch or while locked");
	AST_BUSY_HOLD: assert property ($rose(IN_PROGRESS) |-> CS_N ##0 busy_run)
		else $error("busy did not start at frame end or dropped early");
	AST_DONE_LATCH: assert property ($fell(IN_PROGRESS) |-> !WRITE_LATCH)
		else $error("latch kept after completion");
	AST_PARAM_QPI: assert property ($changed(READ_PARAM) && READ_PARAM != 8'h00 |-> $past(QPI_MODE))
		else $error("read parameters set outside nibble mode");
	AST_RST_CLEAR: assert property ($rose(RESET_RECOVERY) |=> READ_PARAM == 8'h00 && !WRITE_LATCH && !QPI_MODE)
		else $error("software reset left state behind");
	AST_RECOVERY_REFUSE: assert property ($rose(WRITE_LATCH) |-> !$past(RESET_RECOVERY))
		else $error("command taken during recovery");
endmodule // sfq_core_sva
bind sfq_core sfq_core_sva u_sva (.CLK(CLK), .SRST(SRST), .CS_N(CS_N), .IO_OE(IO_OE),
	.QUAD_ENABLE(QUAD_ENABLE), .SECURITY_LOCK(SECURITY_LOCK), .IN_PROGRESS(IN_PROGRESS),
	.WRITE_LATCH(WRITE_LATCH), .QPI_MODE(QPI_MODE), .READ_PARAM(READ_PARAM), .RESET_RECOVERY(RESET_RECOVERY));

// file: tb/sfq_core_bench.sv
// Purpose: self-checking bench for the flash command interpreter
// Assumes: shortened erase and recovery counts
// Notes:   array data mirrors the low address byte
`timescale 1ns/1ps
module sfq_core_bench;
	logic        clk, srst, sclk, cs_n, qe, lock, in_prog, wl, qpi, rrec;
	logic [3:0]  io_in, io_out, io_oe;
	logic [23:0] a_addr;
	logic [7:0]  rp, w;
	int          n_fail = 0;
	int          n_checks = 0;
	int          cyc = 0;
	sfq_core #(.SE_CYCLES(24'h00_044C), .RST_CYCLES(24'h00_00C8)) dut (.CLK(clk), .SRST(srst), .SCLK(sclk),
		.CS_N(cs_n), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe), .QUAD_ENABLE(qe), .SECURITY_LOCK(lock),
		.ARRAY_DATA(a_addr[7:0]), .ARRAY_ADDR(a_addr), .IN_PROGRESS(in_prog), .WRITE_LATCH(wl),
		.QPI_MODE(qpi), .READ_PARAM(rp), .RESET_RECOVERY(rrec));
	sfq_host host (.clk(clk), .io_out(io_out), .io_oe(io_oe), .sclk(sclk), .cs_n(cs_n), .io_in(io_in));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic stop_test();
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			$display("Error at %0t: run did not finish in time", $time);
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic op(input logic [7:0] c);
		host.frm({c, 56'h0}, 8, 1'b0);
	endtask
	task automatic idle();
		for (int i = 0; i < 3000 && in_prog !== 1'b0; i++) host.wt(1);
		chk(in_prog, 1'b0);
	endtask
	task automatic t_reset();
		chk(rp, 8'h00);
		chk(qpi, 1'b0);
	endtask
	task automatic t_erase();
		host.frm({8'h44, 56'h0}, 32, 1'b0);
		chk(in_prog, 1'b0);
		op(8'h06);
		host.frm({8'h44, 56'h0}, 33, 1'b0);
		chk(in_prog, 1'b0);
		host.frm({8'h44, 56'h0}, 32, 1'b0);
		chk(in_prog, 1'b1);
		host.frm({8'h05, 56'h0}, 16, 1'b0);
		chk(host.rd[7:0], 8'h03);
		idle();
		chk(wl, 1'b0);
	endtask
	task automatic t_prog();
		op(8'h06);
		host.frm({8'h42, 24'h00_03FE, 16'hA53C, 16'h0}, 48, 1'b0);
		chk(in_prog, 1'b1);
		idle();
		host.frm({8'h48, 24'h00_03FE, 32'h0}, 64, 1'b0);
		chk(host.rd[23:0], 24'hA5_3CFF);
	endtask
	task automatic t_lock();
		lock = 1'b1;
		op(8'h06);
		host.frm({8'h44, 56'h0}, 32, 1'b0);
		chk(in_prog, 1'b0);
		host.frm({8'h42, 56'h0}, 40, 1'b0);
		chk(in_prog, 1'b0);
		lock = 1'b0;
	endtask
	task automatic t_mode();
		op(8'h38);
		chk(qpi, 1'b0);
		host.frm({8'hC0, 8'h33, 48'h0}, 16, 1'b0);
		chk(rp, 8'h00);
		qe = 1'b1;
		op(8'h38);
		chk(qpi, 1'b1);
		chk(wl, 1'b1);
		for (int c = 0; c < 4; c++) begin
			w = 8'h08 << c;
			host.frm({8'hC0, 2'b00, c[1:0], 2'b00, c[1:0], 48'h0}, 4, 1'b1);
			chk(rp, {2'b00, c[1:0], 2'b00, c[1:0]});
			host.frm({8'h0C, 16'h0000, w - 8'h01, 32'h0}, 14 + 2 * c, 1'b1);
			chk(host.rd[15:0], {w - 8'h01, 8'h00});
		end
		// sector read in nibble mode: 8 dummy clocks, then wrap from the last offset
		host.frm({8'h48, 24'h00_03FF, 32'h0}, 20, 1'b1);
		chk(host.rd[15:0], 16'h3CFF);
		host.frm({8'hFF, 56'h0}, 2, 1'b1);
		chk(qpi, 1'b0);
		chk({wl, rp}, {1'b1, 8'h33});
	endtask
	task automatic t_swrst();
		idle();
		op(8'h66);
		op(8'h06);
		op(8'h99);
		chk(rrec, 1'b0);
		op(8'h66);
		op(8'h99);
		chk(rrec, 1'b1);
		chk({wl, rp}, 9'h000);
		op(8'h06);
		chk(wl, 1'b0);
		for (int i = 0; i < 400 && rrec !== 1'b0; i++) host.wt(1);
		chk(rrec, 1'b0);
	endtask
	initial begin
		qe = 1'b0;
		lock = 1'b0;
		srst = 1'b1;
		repeat (4) @(posedge clk);
		#1 srst = 1'b0;
		host.wt(4);
		t_reset();
		t_erase();
		t_prog();
		t_lock();
		t_mode();
		t_swrst();
		stop_test();
	end
endmodule // sfq_core_bench
